// ===== pkg/camfs_pkg.sv
// Register map, field layout, reset values and modes of the capture block
package camfs_pkg;

    // ****************************************
    // Register byte offsets
    // ****************************************
    localparam logic [7:0] CTRL_OFS = 8'h08;
    localparam logic [7:0] MASK_OFS = 8'h0C;
    localparam logic [7:0] STAT_OFS = 8'h10;
    localparam logic [7:0] CODE_OFS = 8'h14;
    localparam logic [7:0] DATA_OFS = 8'h30;

    // ****************************************
    // Control register fields
    // ****************************************
    localparam int MODE_LSB = 0;
    localparam int MODE_MSB = 1;
    localparam int ESEL_BIT = 4;
    localparam int WM_LSB = 5;
    localparam int WM_MSB = 9;
    localparam logic [4:0] WM_RESET = 5'h01;

    // ****************************************
    // Status and mask fields
    // ****************************************
    localparam int DONE_BIT = 0;
    localparam int FULL_BIT = 1;
    localparam int WMK_BIT = 2;
    localparam int NEMP_BIT = 3;
    localparam int STAT_W = 4;

    // ****************************************
    // Sync-code register fields
    // ****************************************
    localparam int SAV_LSB = 0;
    localparam int SAV_MSB = 7;
    localparam int EAV_LSB = 8;
    localparam int EAV_MSB = 15;
    localparam logic [7:0] SAV_RESET = 8'h80;
    localparam logic [7:0] EAV_RESET = 8'h9D;

    // ****************************************
    // Capture modes and FIFO geometry
    // ****************************************
    typedef enum logic [1:0]
    {
        CAMFS_OFF = 2'h0,
        CAMFS_SINGLE = 2'h1,
        CAMFS_CONT = 2'h2,
        CAMFS_RSVD = 2'h3
    } camfs_mode_t;

    localparam int FIFO_DEPTH = 8;
    localparam int FIFO_WIDTH = 32;

endpackage

// ===== core/camfs_fifo.sv
// Capture word FIFO with occupancy count
`timescale 1ns/1ps
module camfs_fifo
#(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8,
    parameter int CW = $clog2(DEPTH + 1)
)
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic push,
    input wire logic [WIDTH-1:0] push_data,
    input wire logic pop,
    output logic [WIDTH-1:0] head,
    output logic [CW-1:0] count_q
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic do_push;
    logic do_pop;

    assign do_pop = pop && (count_q != '0);
    assign do_push = push && (count_q != FULL_CNT);
    assign head = mem[rd_q];

    function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
        inc = (p == LAST) ? '0 : p + AW'(1);
    endfunction

    always_ff @(posedge mclk)
    begin
        if (clk_en && do_push)
        begin
            mem[wr_q] <= push_data;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            wr_q <= '0;
            rd_q <= '0;
            count_q <= '0;
        end
        else if (clk_en)
        begin
            if (do_push)
            begin
                wr_q <= inc(wr_q);
            end
            if (do_pop)
            begin
                rd_q <= inc(rd_q);
            end
            if (do_push && !do_pop)
            begin
                count_q <= count_q + CW'(1);
            end
            else if (do_pop && !do_push)
            begin
                count_q <= count_q - CW'(1);
            end
        end
    end
endmodule

// ===== core/camfs_top.sv
// Camera capture FIFO, status flags, sync codes and register port
//
// What this block does
// - not-empty flag set while FIFO holds a word, clears when drained.
// - watermark flag set while count is at least the watermark setting.
// - FIFO holds eight 32-bit words; full flag when all eight occupied.
// - full flag drops by hardware as soon as a word is read.
// - frame-end set during capture by frame-sync pin toggle (sync select 0) or EAV match (sync select 1).
// - frame-end flag sticky until software writes one; zero has no effect.
// - EAV code in sync register bits 15:8, reset 0x9D, matched on stream.
// - SAV code in sync register bits 7:0, reset 0x80, matched on stream.
// - FIFO data read returns oldest word and removes it.
// - embedded sync select picks pins (0) or embedded codes (1).
// - mode 0 off, 1 single image, 2 continuous, 3 reserved.
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
module camfs_top
#(
    parameter int DEPTH = camfs_pkg::FIFO_DEPTH,
    parameter int WIDTH = camfs_pkg::FIFO_WIDTH
)
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic pix_valid,
    input wire logic [WIDTH-1:0] pix_data,
    output logic pix_ready,
    input wire logic code_valid,
    input wire logic [7:0] code_byte,
    input wire logic frame_sync_pin,
    input wire logic line_sync_pin,
    output logic capture_active,
    output logic irq
);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

    // ****************************************
    // Declarations
    // ****************************************
    camfs_pkg::camfs_mode_t mode_q;
    logic esel_q;
    logic [4:0] wm_q;
    logic [camfs_pkg::STAT_W-1:0] mask_q;
    logic [7:0] sav_q;
    logic [7:0] eav_q;
    logic done_q;
    logic active_q;
    logic video_on_q;
    logic [31:0] rdata_q;
    logic [1:0] fs_sync_q;
    logic fs_prev_q;
    logic [1:0] ls_sync_q;
    logic [CW-1:0] count;
    logic [WIDTH-1:0] head;
    logic flag_nemp;
    logic flag_wmk;
    logic flag_full;
    logic [camfs_pkg::STAT_W-1:0] status;
    logic fs_edge;
    logic sav_hit;
    logic eav_hit;
    logic frame_end;
    logic line_open;
    logic push;
    logic pop;

    function automatic logic hit(input logic [7:0] a,
                                 input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    // ****************************************
    // Capture FIFO
    // ****************************************
    camfs_fifo #(
        .WIDTH(WIDTH),
        .DEPTH(DEPTH),
        .CW(CW)
    ) u_fifo (
        .mclk(mclk),
        .reset(reset),
        .clk_en(clk_en),
        .push(push),
        .push_data(pix_data),
        .pop(pop),
        .head(head),
        .count_q(count)
    );

    // Words enter only while capturing and inside an active line
    assign line_open = esel_q ? video_on_q : ls_sync_q[1];
    assign pix_ready = active_q && line_open && (count != FULL_CNT);
    assign push = pix_valid && pix_ready;
    assign pop = reg_rd && hit(reg_addr, camfs_pkg::DATA_OFS);

    // ****************************************
    // Level flags
    // ****************************************
    assign flag_nemp = (count != '0);
    assign flag_wmk = ({{(32-CW){1'b0}}, count} >= {27'h0, wm_q});
    assign flag_full = (count == FULL_CNT);

    always_comb
    begin
        status = '0;
        status[camfs_pkg::NEMP_BIT] = flag_nemp;
        status[camfs_pkg::WMK_BIT] = flag_wmk;
        status[camfs_pkg::FULL_BIT] = flag_full;
        status[camfs_pkg::DONE_BIT] = done_q;
    end

    assign irq = |(status & mask_q);
    assign capture_active = active_q;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            fs_sync_q <= '0;
            fs_prev_q <= 1'b0;
            ls_sync_q <= '0;
        end
        else if (clk_en)
        begin
            fs_sync_q <= {fs_sync_q[0], frame_sync_pin};
            fs_prev_q <= fs_sync_q[1];
            ls_sync_q <= {ls_sync_q[0], line_sync_pin};
        end
    end

    // ****************************************
    // Frame end detection
    // ****************************************
    assign fs_edge = fs_sync_q[1] ^ fs_prev_q;
    assign sav_hit = code_valid && (code_byte == sav_q);
    assign eav_hit = code_valid && (code_byte == eav_q);
    assign frame_end = active_q && (esel_q ? eav_hit : fs_edge);

    // Active video window in embedded mode
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            video_on_q <= 1'b0;
        end
        else if (clk_en)
        begin
            if (eav_hit)
            begin
                video_on_q <= 1'b0;
            end
            else if (sav_hit)
            begin
                video_on_q <= 1'b1;
            end
        end
    end

    // Capture run state; single mode stops at the first frame end
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            active_q <= 1'b0;
        end
        else if (clk_en)
        begin
            if (reg_wr && hit(reg_addr, camfs_pkg::CTRL_OFS))
            begin
                active_q <= (reg_wdata[camfs_pkg::MODE_MSB:
                    camfs_pkg::MODE_LSB] == camfs_pkg::CAMFS_SINGLE) ||
                    (reg_wdata[camfs_pkg::MODE_MSB:camfs_pkg::MODE_LSB] ==
                    camfs_pkg::CAMFS_CONT);
            end
            else if (frame_end && (mode_q == camfs_pkg::CAMFS_SINGLE))
            begin
                active_q <= 1'b0;
            end
        end
    end

    // Sticky frame-end flag, set wins over write-one clear
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            done_q <= 1'b0;
        end
        else if (clk_en)
        begin
            if (frame_end)
            begin
                done_q <= 1'b1;
            end
            else if (reg_wr && hit(reg_addr, camfs_pkg::STAT_OFS) &&
                     reg_wdata[camfs_pkg::DONE_BIT])
            begin
                done_q <= 1'b0;
            end
        end
    end

    // ****************************************
    // Register writes
    // ****************************************
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            mode_q <= camfs_pkg::CAMFS_OFF;
            esel_q <= 1'b0;
            wm_q <= camfs_pkg::WM_RESET;
        end
        else if (clk_en && reg_wr && hit(reg_addr, camfs_pkg::CTRL_OFS))
        begin
            mode_q <= camfs_pkg::camfs_mode_t'(
                reg_wdata[camfs_pkg::MODE_MSB:camfs_pkg::MODE_LSB]);
            esel_q <= reg_wdata[camfs_pkg::ESEL_BIT];
            wm_q <= reg_wdata[camfs_pkg::WM_MSB:camfs_pkg::WM_LSB];
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            mask_q <= '0;
        end
        else if (clk_en && reg_wr && hit(reg_addr, camfs_pkg::MASK_OFS))
        begin
            mask_q <= reg_wdata[camfs_pkg::STAT_W-1:0];
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            sav_q <= camfs_pkg::SAV_RESET;
            eav_q <= camfs_pkg::EAV_RESET;
        end
        else if (clk_en && reg_wr && hit(reg_addr, camfs_pkg::CODE_OFS))
        begin
            sav_q <= reg_wdata[camfs_pkg::SAV_MSB:camfs_pkg::SAV_LSB];
            eav_q <= reg_wdata[camfs_pkg::EAV_MSB:camfs_pkg::EAV_LSB];
        end
    end

    // ****************************************
    // Register reads, data one cycle later
    // ****************************************
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            rdata_q <= '0;
        end
        else if (clk_en)
        begin
            rdata_q <= '0;
            if (reg_rd)
            begin
                unique case (reg_addr)
                    camfs_pkg::CTRL_OFS:
                    begin
                        rdata_q[camfs_pkg::MODE_MSB:camfs_pkg::MODE_LSB] <=
                            mode_q;
                        rdata_q[camfs_pkg::ESEL_BIT] <= esel_q;
                        rdata_q[camfs_pkg::WM_MSB:camfs_pkg::WM_LSB] <= wm_q;
                    end
                    camfs_pkg::MASK_OFS:
                    begin
                        rdata_q[camfs_pkg::STAT_W-1:0] <= mask_q;
                    end
                    camfs_pkg::STAT_OFS:
                    begin
                        rdata_q[camfs_pkg::STAT_W-1:0] <= status;
                    end
                    camfs_pkg::CODE_OFS:
                    begin
                        rdata_q[camfs_pkg::SAV_MSB:camfs_pkg::SAV_LSB] <=
                            sav_q;
                        rdata_q[camfs_pkg::EAV_MSB:camfs_pkg::EAV_LSB] <=
                            eav_q;
                    end
                    camfs_pkg::DATA_OFS:
                    begin
                        if (flag_nemp)
                        begin
                            rdata_q <= 32'(head);
                        end
                    end
                    default:
                    begin
                        rdata_q <= '0;
                    end
                endcase
            end
        end
    end

    assign reg_rdata = rdata_q;
endmodule

// ===== testbench/camfs_properties.sv
// Concurrent checks on the capture block's register port and flags
`timescale 1ns/1ps
module camfs_properties
#(
    parameter int DEPTH = 8
)
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic pix_valid,
    input wire logic pix_ready,
    input wire logic capture_active
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (reset);
    int cnt_q;
    logic [4:0] wm_q;
    logic rd_st;
    logic rd_cd;
    logic pop;
    logic wr_ct;
    logic [2:0] lvl;
    assign rd_st = clk_en && reg_rd && reg_addr == camfs_pkg::STAT_OFS;
    assign rd_cd = clk_en && reg_rd && reg_addr == camfs_pkg::CODE_OFS;
    assign pop = clk_en && reg_rd && reg_addr == camfs_pkg::DATA_OFS;
    assign wr_ct = clk_en && reg_wr && reg_addr == camfs_pkg::CTRL_OFS;
    // Level flags follow the count in the same cycle
    assign lvl = {cnt_q != 0, cnt_q >= int'(wm_q), cnt_q == DEPTH};
    // Shadow of occupancy and watermark seen from the ports
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            cnt_q <= 0;
            wm_q <= camfs_pkg::WM_RESET;
        end
        else if (clk_en)
        begin
            cnt_q <= cnt_q + int'(pix_valid && pix_ready)
                - int'(pop && cnt_q != 0);
            if (wr_ct)
            begin
                wm_q <= reg_wdata[9:5];
            end
        end
    end
    chk_nempty_flag: assert property (
        rd_st |=> reg_rdata[3] == $past(lvl[2]))
        else $error("not-empty flag wrong");
    chk_wmark_flag: assert property (
        rd_st |=> reg_rdata[2] == $past(lvl[1]))
        else $error("watermark flag wrong");
    chk_full_flag: assert property (
        rd_st |=> reg_rdata[1] == $past(lvl[0]))
        else $error("full flag wrong");
    chk_ready_room: assert property (
        pix_ready |-> cnt_q < DEPTH)
        else $error("word offered room past depth");
    chk_stat_rsvd: assert property (
        rd_st |=> reg_rdata[31:4] == 28'h0)
        else $error("status upper bits not zero");
    chk_code_rsvd: assert property (
        rd_cd |=> reg_rdata[31:16] == 16'h0)
        else $error("sync code upper bits not zero");
    chk_mode_stop: assert property (
        wr_ct && reg_wdata[1:0] inside {2'h0, 2'h3} |=> !capture_active)
        else $error("run not stopped");
    chk_mode_run: assert property (
        wr_ct && reg_wdata[1:0] inside {2'h1, 2'h2} |=> capture_active)
        else $error("run not started");
    cover property (rd_st && cnt_q == DEPTH);
    cover property (pop && cnt_q == DEPTH ##1 pix_ready);
    cover property (capture_active ##1 !capture_active);
endmodule

// ===== testbench/camfs_sensor.sv
// Sensor model: pixel words, embedded sync codes and sync pins
`timescale 1ns/1ps
module camfs_sensor
(
    input wire logic mclk,
    input wire logic go,
    input wire logic esel,
    input wire logic [3:0] nwords,
    input wire logic [31:0] base,
    input wire logic [7:0] sav,
    input wire logic [7:0] eav,
    input wire logic pix_ready,
    output logic pix_valid,
    output logic [31:0] pix_data,
    output logic code_valid,
    output logic [7:0] code_byte,
    output logic frame_sync_pin,
    output logic line_sync_pin,
    output logic busy
);
    int i;
    logic t;
    task automatic code(input logic [7:0] b);
        code_valid <= 1'b1;
        code_byte <= b;
        @(posedge mclk);
        code_valid <= 1'b0;
        code_byte <= ~b;
    endtask
    initial
    begin
        {pix_valid, code_valid, frame_sync_pin, line_sync_pin, busy} = 5'h00;
        pix_data = 32'h0;
        code_byte = 8'h00;
        forever
        begin
            @(posedge mclk);
            if (go)
            begin
                busy <= 1'b1;
                line_sync_pin <= 1'b1;
                if (esel)
                    code(sav);
                i = 0;
                while (i < int'(nwords))
                begin
                    pix_valid <= 1'b1;
                    pix_data <= base + 32'(i);
                    @(negedge mclk);
                    t = pix_ready;
                    @(posedge mclk);
                    i = i + int'(t);
                    // Slow sensor: idle gap with a scrambled bus
                    if (t && $urandom_range(3) == 0)
                    begin
                        pix_valid <= 1'b0;
                        pix_data <= ~pix_data;
                        @(posedge mclk);
                    end
                end
                pix_valid <= 1'b0;
                pix_data <= ~pix_data;
                if (esel)
                    code(eav);
                else
                    frame_sync_pin <= ~frame_sync_pin;
                line_sync_pin <= 1'b0;
                busy <= 1'b0;
            end
        end
    end
endmodule

// ===== testbench/tb_top.sv
// Top bench: register traffic, capture runs and flag checks
`timescale 1ns/1ps
module tb_top;
    localparam logic [7:0] CT = camfs_pkg::CTRL_OFS;
    localparam logic [7:0] MK = camfs_pkg::MASK_OFS;
    localparam logic [7:0] ST = camfs_pkg::STAT_OFS;
    localparam logic [7:0] CD = camfs_pkg::CODE_OFS;
    localparam logic [7:0] DT = camfs_pkg::DATA_OFS;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic clk_en = 1'b1;
    logic [31:0] reg_rdata, pix_data, d;
    logic pix_valid, pix_ready, code_valid, capture_active, irq, busy;
    logic frame_sync_pin, line_sync_pin;
    logic [7:0] code_byte;
    logic go = 1'b0;
    logic esel = 1'b0;
    logic [3:0] nwords = 4'h0;
    logic [31:0] base = 32'h0;
    logic [7:0] sav, eav;
    logic [4:0] wm;
    int miscompares = 0;
    int checks = 0;
    always #5 mclk = ~mclk;
    camfs_top DUT (.mclk(mclk), .reset(reset), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pix_valid(pix_valid),
        .pix_data(pix_data), .pix_ready(pix_ready), .code_valid(code_valid),
        .code_byte(code_byte), .frame_sync_pin(frame_sync_pin),
        .line_sync_pin(line_sync_pin), .capture_active(capture_active),
        .irq(irq));
    camfs_sensor u_sensor (.mclk(mclk), .go(go), .esel(esel),
        .nwords(nwords), .base(base), .sav(sav), .eav(eav),
        .pix_ready(pix_ready), .pix_valid(pix_valid), .pix_data(pix_data),
        .code_valid(code_valid), .code_byte(code_byte), .busy(busy),
        .frame_sync_pin(frame_sync_pin), .line_sync_pin(line_sync_pin));
    task automatic check(input string nm, input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic run(input logic e, input logic [3:0] n);
        go <= 1'b1;
        esel <= e;
        nwords <= n;
        base <= $urandom;
        @(posedge mclk);
        go <= 1'b0;
    endtask
    task automatic idle();
        repeat (6) @(posedge mclk);
        for (int k = 0; k < 300 && busy !== 1'b0; k++)
            @(posedge mclk);
        repeat (6) @(posedge mclk);
    endtask
    function automatic logic [31:0] flg(input int c, input logic dn);
        return {28'h0, c != 0, c >= int'(wm), c == 8, dn};
    endfunction
    task automatic test_done();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        void'($urandom(83));
        sav = 8'h80;
        eav = 8'h9D;
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        rd(ST);
        check("status reset", d, 32'h0);
        rd(CD);
        check("eav reset", d[15:8], 8'h9D);
        check("sav reset", d[7:0], 8'h80);
        rd(8'h20);
        check("unmapped", d, 32'h0);
        sav = 8'($urandom_range(255));
        eav = sav ^ 8'($urandom_range(255, 1));
        wr(CD, {16'hFFFF, eav, sav});
        rd(CD);
        check("codes", d, {16'h0, eav, sav});
        // A write while the clock enable is low must not land
        @(posedge mclk);
        clk_en <= 1'b0;
        wr(CD, 32'h0);
        clk_en <= 1'b1;
        rd(CD);
        check("frozen", d, {16'h0, eav, sav});
        wr(ST, 32'hFFFFFFFF);
        rd(ST);
        check("flag write", d, 32'h0);
        for (int m = 0; m < 4; m++)
        begin
            wr(CT, 32'(m));
            #1 check("run", capture_active, m == 1 || m == 2);
        end
        wm = 5'($urandom_range(8, 1));
        wr(MK, 32'h8);
        wr(CT, {22'h0, wm, 5'h02});
        run(1'b0, 4'h9);
        d = 32'h0;
        for (int k = 0; k < 60 && d[1] !== 1'b1; k++)
            rd(ST);
        check("full", d, flg(8, 1'b0));
        check("irq", irq, 1'b1);
        wr(ST, 32'hE);
        rd(ST);
        check("flag keep", d, flg(8, 1'b0));
        for (int i = 0; i < 9; i++)
        begin
            rd(DT);
            check("word", d, base + 32'(i));
            if (i == 0)
                check("room", pix_ready, 1'b1);
            repeat (4) @(posedge mclk);
            rd(ST);
            check("levels", d & 32'hE, flg(8 - i, 1'b0));
        end
        idle();
        rd(ST);
        check("pin end", d, 32'h1);
        check("still on", capture_active, 1'b1);
        rd(DT);
        check("empty read", d, 32'h0);
        wr(ST, 32'h0);
        wr(MK, 32'h1);
        rd(ST);
        check("done kept", d, 32'h1);
        check("irq done", irq, 1'b1);
        wr(ST, 32'h1);
        rd(ST);
        check("done clear", d, 32'h0);
        check("irq clear", irq, 1'b0);
        wr(CT, {22'h0, wm, 5'h11});
        run(1'b1, 4'h3);
        idle();
        check("single stop", capture_active, 1'b0);
        rd(ST);
        check("code end", d, flg(3, 1'b1));
        for (int i = 0; i < 3; i++)
        begin
            rd(DT);
            check("code word", d, base + 32'(i));
        end
        test_done();
    end
    initial
    begin
        #300000;
        miscompares++;
        test_done();
    end
endmodule
bind camfs_top camfs_properties #(.DEPTH(DEPTH)) u_chk (.mclk(mclk),
    .reset(reset), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pix_valid(pix_valid), .pix_ready(pix_ready),
    .capture_active(capture_active));
